// ### include/comparator_pkg.sv
// Constants shared by the comparator control and status logic.
// Assumes an 8-bit data-space register bus with a separate I/O-space address path.
package comparator_pkg;
    localparam logic [7:0] STATUS_DATA_OFFSET = 8'h50;
    localparam logic [7:0] IO_SPACE_BIAS = 8'h20;
    localparam logic [5:0] STATUS_IO_OFFSET = 6'h30;
    localparam logic [7:0] PIN_DISABLE_OFFSET = 8'h7F;
    localparam int POWER_OFF_BIT = 7;
    localparam int BANDGAP_BIT = 6;
    localparam int RESULT_BIT = 5;
    localparam int FLAG_BIT = 4;
    localparam int IRQ_ENABLE_BIT = 3;
    localparam int CAPTURE_BIT = 2;
    localparam int POSITIVE_OFF_BIT = 0;
    localparam int NEGATIVE_OFF_BIT = 1;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [1:0] PIN_DISABLE_RESET = 2'h0;
    localparam logic [1:0] EVENT_TOGGLE = 2'h0;
    localparam logic [1:0] EVENT_RESERVED = 2'h1;
    localparam logic [1:0] EVENT_FALLING = 2'h2;
    localparam logic [1:0] EVENT_RISING = 2'h3;
    localparam int SYNC_STAGES = 2;
endpackage

// ### src/comparator_control_status.sv
// Control and status registers around the analog comparator.
// Assumes a CPU bus with one-cycle read and write strobes, data-space and I/O addresses.
`timescale 1ns/1ps
`default_nettype none
module comparator_control_status
    import comparator_pkg::*;
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic reset_n_in,
    // Data-space access
    input wire logic [7:0] data_addr_in,
    input wire logic data_write_in,
    input wire logic data_read_in,
    // I/O-space access
    input wire logic [5:0] io_addr_in,
    input wire logic io_write_in,
    input wire logic io_read_in,
    input wire logic [7:0] write_data_in,
    output logic [7:0] read_data_out,
    // Interrupt handshake
    input wire logic global_irq_enable_in,
    input wire logic vector_taken_in,
    output logic irq_request_out,
    // Analog comparator core
    input wire logic positive_above_negative_in,
    output logic comparator_power_off_out,
    output logic bandgap_positive_select_out,
    // Negative input selection
    input wire logic negative_mux_enable_in,
    input wire logic converter_enable_in,
    input wire logic [2:0] channel_select_low_in,
    output logic use_converter_pin_out,
    output logic [2:0] negative_channel_out,
    // Timer capture front end
    output logic capture_route_enable_out,
    output logic capture_signal_out,
    // Pin buffers
    input wire logic positive_pin_digital_in,
    input wire logic negative_pin_digital_in,
    output logic positive_pin_buffer_off_out,
    output logic negative_pin_buffer_off_out,
    output logic positive_pin_port_out,
    output logic negative_pin_port_out
);
    logic power_off_q;
    logic bandgap_q;
    logic flag_q;
    logic irq_enable_q;
    logic capture_q;
    logic [1:0] event_select_q;
    logic [1:0] pin_off_q;
    logic synced_compare_result;
    logic event_seen;
    logic status_write;
    logic status_read;
    logic pin_write;
    logic pin_read;
    logic raw_result;

    // Both address spaces reach the same status register.
    assign status_write = (data_write_in && data_addr_in == STATUS_DATA_OFFSET)
        || (io_write_in && io_addr_in == STATUS_IO_OFFSET);
    assign status_read = (data_read_in && data_addr_in == STATUS_DATA_OFFSET)
        || (io_read_in && io_addr_in == STATUS_IO_OFFSET);
    assign pin_write = data_write_in && data_addr_in == PIN_DISABLE_OFFSET;
    assign pin_read = data_read_in && data_addr_in == PIN_DISABLE_OFFSET;

    // A powered-off comparator reports low rather than a floating result.
    assign raw_result = positive_above_negative_in & ~power_off_q;

    compare_event_detect detect (
        .clock_in(clock_in),
        .reset_n_in(reset_n_in),
        .raw_result_in(raw_result),
        .event_select_in(event_select_q),
        .synced_result_out(synced_compare_result),
        .event_out(event_seen)
    );

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            power_off_q <= STATUS_RESET[POWER_OFF_BIT];
            bandgap_q <= STATUS_RESET[BANDGAP_BIT];
            irq_enable_q <= STATUS_RESET[IRQ_ENABLE_BIT];
            capture_q <= STATUS_RESET[CAPTURE_BIT];
            event_select_q <= STATUS_RESET[1:0];
        end else if (status_write) begin
            power_off_q <= write_data_in[POWER_OFF_BIT];
            bandgap_q <= write_data_in[BANDGAP_BIT];
            irq_enable_q <= write_data_in[IRQ_ENABLE_BIT];
            capture_q <= write_data_in[CAPTURE_BIT];
            event_select_q <= write_data_in[1:0];
        end
    end

    // A new event wins over a clear in the same cycle so it is never lost.
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            flag_q <= STATUS_RESET[FLAG_BIT];
        end else if (event_seen) begin
            flag_q <= 1'b1;
        end else if (vector_taken_in || (status_write && write_data_in[FLAG_BIT])) begin
            flag_q <= 1'b0;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            pin_off_q <= PIN_DISABLE_RESET;
        end else if (pin_write) begin
            pin_off_q <= {write_data_in[NEGATIVE_OFF_BIT], write_data_in[POSITIVE_OFF_BIT]};
        end
    end

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            read_data_out <= 8'h00;
        end else if (status_read) begin
            read_data_out <= {power_off_q, bandgap_q, synced_compare_result, flag_q,
                irq_enable_q, capture_q, event_select_q};
        end else if (pin_read) begin
            read_data_out <= {6'h00, pin_off_q};
        end else begin
            read_data_out <= 8'h00;
        end
    end

    assign irq_request_out = flag_q & irq_enable_q & global_irq_enable_in;
    assign comparator_power_off_out = power_off_q;
    assign bandgap_positive_select_out = bandgap_q;
    assign use_converter_pin_out = negative_mux_enable_in & ~converter_enable_in;
    assign negative_channel_out = use_converter_pin_out ? channel_select_low_in : 3'h0;
    assign capture_route_enable_out = capture_q;
    assign capture_signal_out = capture_q & synced_compare_result;
    assign positive_pin_buffer_off_out = pin_off_q[POSITIVE_OFF_BIT];
    assign negative_pin_buffer_off_out = pin_off_q[NEGATIVE_OFF_BIT];
    assign positive_pin_port_out = positive_pin_digital_in & ~pin_off_q[POSITIVE_OFF_BIT];
    assign negative_pin_port_out = negative_pin_digital_in & ~pin_off_q[NEGATIVE_OFF_BIT];

    a_flag_on_event: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        event_seen |=> flag_q)
        else $error("event did not set flag");
    a_flag_cleared: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (vector_taken_in && !event_seen) |=> !flag_q)
        else $error("vector did not clear flag");
    a_flag_write_clear: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (status_write && write_data_in[FLAG_BIT] && !event_seen) |=> !flag_q)
        else $error("flag write of one did not clear");
    // A zero written to the flag bit must leave a pending event in place.
    a_flag_write_hold: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (status_write && !write_data_in[FLAG_BIT] && !vector_taken_in && !event_seen) |=> flag_q == $past(flag_q))
        else $error("flag write of zero changed flag");
    a_irq_gating: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        irq_request_out |-> (flag_q && irq_enable_q && global_irq_enable_in))
        else $error("interrupt without all enables");
    a_enable_write: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (status_write && !write_data_in[IRQ_ENABLE_BIT]) |=> !irq_request_out)
        else $error("cleared enable left request");
    a_power_write: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        status_write |=> comparator_power_off_out == $past(write_data_in[POWER_OFF_BIT]))
        else $error("power-off bit not stored");
    a_power_quiet: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        comparator_power_off_out |-> !raw_result)
        else $error("powered-off comparator reported high");
    a_bandgap_write: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        status_write |=> bandgap_positive_select_out == $past(write_data_in[BANDGAP_BIT]))
        else $error("bandgap select not stored");
    // The synchroniser restarts from zero, so its first two cycles after reset are not compared.
    a_sync_delay: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        $past(reset_n_in, 2) |-> $past(raw_result, 2) == synced_compare_result)
        else $error("synchroniser latency wrong");
    a_result_read: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        status_read |=> read_data_out[RESULT_BIT] == $past(synced_compare_result))
        else $error("status read lost comparator result");
    a_capture_off: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        !capture_route_enable_out |-> !capture_signal_out)
        else $error("capture path active while off");
    a_capture_follow: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        capture_route_enable_out |-> capture_signal_out == synced_compare_result)
        else $error("capture path does not follow result");
    a_reserved_quiet: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (event_select_q == EVENT_RESERVED) |-> !event_seen)
        else $error("reserved mode raised event");
    a_negative_mux: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (negative_mux_enable_in && !converter_enable_in)
        |-> (use_converter_pin_out && negative_channel_out == channel_select_low_in))
        else $error("negative input mux not applied");
    a_pin_zero: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        positive_pin_buffer_off_out |-> !positive_pin_port_out)
        else $error("disabled pin read nonzero");
    a_neg_pin_zero: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        negative_pin_buffer_off_out |-> !negative_pin_port_out)
        else $error("disabled negative pin read nonzero");
    a_pin_write: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        pin_write |=> negative_pin_buffer_off_out == $past(write_data_in[NEGATIVE_OFF_BIT])
            && positive_pin_buffer_off_out == $past(write_data_in[POSITIVE_OFF_BIT]))
        else $error("pin disable bits not stored");
    a_io_decode: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (io_read_in && io_addr_in == STATUS_IO_OFFSET && !data_read_in)
        |=> read_data_out[FLAG_BIT] == $past(flag_q))
        else $error("I/O read of status wrong");
endmodule
`default_nettype wire

// ### src/compare_event_detect.sv
// Synchronises the raw comparator result and detects the chosen output event.
// Assumes the raw result is asynchronous to clock_in.
`timescale 1ns/1ps
`default_nettype none
module compare_event_detect
    import comparator_pkg::*;
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic reset_n_in,
    // Comparator side
    input wire logic raw_result_in,
    input wire logic [1:0] event_select_in,
    // Results
    output logic synced_result_out,
    output logic event_out
);
    logic [SYNC_STAGES-1:0] sync_q;
    logic prev_q;

    // The first stage feeds only the second one.
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            sync_q <= '0;
            prev_q <= 1'b0;
        end else begin
            sync_q <= {sync_q[SYNC_STAGES-2:0], raw_result_in};
            prev_q <= sync_q[SYNC_STAGES-1];
        end
    end

    assign synced_result_out = sync_q[SYNC_STAGES-1];

    always_comb begin
        unique case (event_select_in)
            EVENT_TOGGLE: event_out = synced_result_out ^ prev_q;
            EVENT_RESERVED: event_out = 1'b0;
            EVENT_FALLING: event_out = prev_q & ~synced_result_out;
            EVENT_RISING: event_out = ~prev_q & synced_result_out;
        endcase
    end

    a_event_edge: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        event_out |-> (synced_result_out != $past(synced_result_out)))
        else $error("event without output change");
endmodule
`default_nettype wire

// ### testbench/comparator_control_status_test.sv
// Self-checking bench for the comparator control and status block.
// Assumes the core model drives the raw result while the bench plays the CPU.
`timescale 1ns/1ps
`default_nettype none
module comparator_control_status_test;
    import comparator_pkg::*;
    logic clock_in, reset_n_in, data_write_in, data_read_in, io_write_in, io_read_in;
    logic global_irq_enable_in, vector_taken_in, irq_request_out, positive_above_negative_in;
    logic comparator_power_off_out, bandgap_positive_select_out, negative_mux_enable_in, converter_enable_in;
    logic use_converter_pin_out, capture_route_enable_out, capture_signal_out, positive_pin_digital_in;
    logic negative_pin_digital_in, positive_pin_buffer_off_out, negative_pin_buffer_off_out;
    logic positive_pin_port_out, negative_pin_port_out, capture_irq_enable;
    logic [7:0] data_addr_in, write_data_in, read_data_out, pos_level, neg_level, q;
    logic [5:0] io_addr_in;
    logic [2:0] channel_select_low_in, negative_channel_out;
    int error_cnt = 0;
    int cmp_count = 0;
    comparator_control_status i_dut (.clock_in, .reset_n_in, .data_addr_in, .data_write_in, .data_read_in,
        .io_addr_in, .io_write_in, .io_read_in, .write_data_in, .read_data_out, .global_irq_enable_in,
        .vector_taken_in, .irq_request_out, .positive_above_negative_in, .comparator_power_off_out,
        .bandgap_positive_select_out, .negative_mux_enable_in, .converter_enable_in, .channel_select_low_in,
        .use_converter_pin_out, .negative_channel_out, .capture_route_enable_out, .capture_signal_out,
        .positive_pin_digital_in, .negative_pin_digital_in, .positive_pin_buffer_off_out,
        .negative_pin_buffer_off_out, .positive_pin_port_out, .negative_pin_port_out);
    comparator_core_model i_core (.power_off_in(comparator_power_off_out),
        .bandgap_select_in(bandgap_positive_select_out), .use_converter_pin_in(use_converter_pin_out),
        .channel_in(negative_channel_out), .positive_level_in(pos_level), .negative_level_in(neg_level),
        .compare_out(positive_above_negative_in));
    task automatic end_sim;
        if (error_cnt == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Strobes stand for exactly one rising edge, and a quiet edge follows so two accesses never touch.
    task automatic bus(input logic io, input logic wr, input logic [7:0] a, input logic [7:0] d);
        data_addr_in = a;
        io_addr_in = a[5:0];
        write_data_in = d;
        {io_write_in, io_read_in, data_write_in, data_read_in} = {io & wr, io & !wr, !io & wr, !io & !wr};
        step(1);
        {io_write_in, io_read_in, data_write_in, data_read_in} = 4'h0;
        q = read_data_out;
        step(1);
    endtask
    task automatic t_regs;
        bus(0, 0, STATUS_DATA_OFFSET, 8'h00);
        chk(q, 8'h00);
        bus(1, 1, {2'h0, STATUS_IO_OFFSET}, 8'h23);
        bus(0, 1, 8'h51, 8'hFF);
        bus(1, 0, {2'h0, STATUS_IO_OFFSET}, 8'h00);
        chk(q, 8'h03);
        bus(0, 0, STATUS_DATA_OFFSET, 8'h00);
        chk(q, 8'h03);
        bus(0, 0, 8'h51, 8'h00);
        chk(q, 8'h00);
        bus(0, 1, STATUS_DATA_OFFSET, 8'h00);
    endtask
    task automatic t_pins;
        {positive_pin_digital_in, negative_pin_digital_in} = 2'h3;
        bus(0, 1, PIN_DISABLE_OFFSET, 8'hFE);
        bus(0, 0, PIN_DISABLE_OFFSET, 8'h00);
        chk(q, 8'h02);
        chk({positive_pin_buffer_off_out, negative_pin_buffer_off_out, positive_pin_port_out,
            negative_pin_port_out}, 8'h06);
        bus(0, 1, PIN_DISABLE_OFFSET, 8'h01);
        chk({positive_pin_buffer_off_out, negative_pin_buffer_off_out, positive_pin_port_out,
            negative_pin_port_out}, 8'h09);
    endtask
    task automatic t_mux;
        for (int i = 0; i < 32; i++) begin
            {negative_mux_enable_in, converter_enable_in, channel_select_low_in} = i[4:0];
            step(1);
            chk({use_converter_pin_out, negative_channel_out}, (i[4:3] == 2'h2) ? {1'b1, i[2:0]} : 4'h0);
        end
        {negative_mux_enable_in, converter_enable_in} = 2'h0;
        step(3);
    endtask
    task automatic t_capture;
        bus(0, 1, STATUS_DATA_OFFSET, 8'h14);
        // The timer only turns a routed edge into an interrupt with its own mask bit set.
        capture_irq_enable = 1'b1;
        pos_level = 8'hF0;
        step(1);
        chk(capture_signal_out, 8'h00);
        step(1);
        chk({capture_route_enable_out, capture_signal_out & capture_irq_enable}, 8'h03);
        bus(0, 1, STATUS_DATA_OFFSET, 8'h10);
        chk(capture_signal_out, 8'h00);
        pos_level = 8'h10;
        step(3);
    endtask
    task automatic t_power;
        bus(0, 1, STATUS_DATA_OFFSET, 8'h50);
        step(4);
        bus(0, 0, STATUS_DATA_OFFSET, 8'h00);
        chk(q, 8'h70);
        bus(0, 1, STATUS_DATA_OFFSET, 8'hD0);
        step(4);
        bus(0, 0, STATUS_DATA_OFFSET, 8'h00);
        chk(q, 8'hD0);
        bus(0, 1, STATUS_DATA_OFFSET, 8'h10);
    endtask
    task automatic t_events;
        global_irq_enable_in = 1'b1;
        for (int s = 0; s < 4; s++) begin
            // The enable stays off while the select changes, or a stray request could appear.
            bus(0, 1, STATUS_DATA_OFFSET, 8'h10 | 8'(s));
            bus(0, 1, STATUS_DATA_OFFSET, 8'h18 | 8'(s));
            pos_level = 8'hF0;
            step(4);
            chk(irq_request_out, s == 0 || s == 3);
            bus(0, 0, STATUS_DATA_OFFSET, 8'h00);
            chk(q, {3'h1, s == 0 || s == 3, 2'h2, s[1:0]});
            vector_taken_in = 1'b1;
            step(1);
            vector_taken_in = 1'b0;
            chk(irq_request_out, 8'h00);
            pos_level = 8'h10;
            step(4);
            chk(irq_request_out, s == 0 || s == 2);
            global_irq_enable_in = 1'b0;
            step(1);
            chk(irq_request_out, 8'h00);
            global_irq_enable_in = 1'b1;
            bus(0, 1, STATUS_DATA_OFFSET, 8'h10 | 8'(s));
            chk(irq_request_out, 8'h00);
        end
    endtask
    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end
    initial begin
        #100000;
        error_cnt++;
        end_sim;
    end
    initial begin
        {reset_n_in, data_write_in, data_read_in, io_write_in, io_read_in, global_irq_enable_in} = 6'h00;
        {vector_taken_in, negative_mux_enable_in, converter_enable_in, positive_pin_digital_in} = 4'h0;
        {negative_pin_digital_in, channel_select_low_in, data_addr_in, write_data_in, io_addr_in} = 26'h0;
        pos_level = 8'h10;
        neg_level = 8'h80;
        repeat (6) @(posedge clock_in);
        #1;
        reset_n_in = 1'b1;
        t_regs;
        t_pins;
        t_mux;
        t_capture;
        t_power;
        t_events;
        end_sim;
    end
endmodule
`default_nettype wire

// ### testbench/comparator_core_model.sv
// Behavioural model of the analog comparator core and its input selection.
// Assumes the bench drives the analog levels as unsigned codes.
`timescale 1ns/1ps
`default_nettype none
module comparator_core_model #(
    parameter logic [7:0] BANDGAP_LEVEL = 8'hA0
) (
    // Controls from the block
    input wire logic power_off_in,
    input wire logic bandgap_select_in,
    input wire logic use_converter_pin_in,
    input wire logic [2:0] channel_in,
    // Analog levels and result
    input wire logic [7:0] positive_level_in,
    input wire logic [7:0] negative_level_in,
    output logic compare_out
);
    logic [7:0] plus_level;
    logic [7:0] minus_level;
    assign plus_level = bandgap_select_in ? BANDGAP_LEVEL : positive_level_in;
    assign minus_level = use_converter_pin_in ? {channel_in, 5'h00} : negative_level_in;
    // A powered-off core reads low, so switching it off can itself look like a falling edge.
    assign compare_out = !power_off_in && (plus_level > minus_level);
endmodule
`default_nettype wire
